//--- core/fsc_host.sv
// Host controller that configures and watches a flash status pin
//
// Chosen here: the address map and the Avalon-MM slave port.
`timescale 1ns/1ns
module fsc_host #(
  parameter logic [7:0] CONFIG_OPCODE = 8'hB8,
  parameter logic [7:0] RDSTAT_OPCODE = 8'h70,
  parameter logic [7:0] CLRSTAT_OPCODE = 8'h50
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  // Avalon-MM slave
  input  wire logic [1:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Interrupt
  output logic             irq,
  // Flash pins
  output logic             flash_ce_n,
  output logic             flash_we_n,
  output logic             flash_oe_n,
  output logic [7:0]       flash_data_out,
  output logic             flash_data_oe,
  input  wire logic [7:0]  flash_data_in,
  output logic             reset_powerdown_n,
  input  wire logic        status_pin,
  // System
  output logic             hold_request
);

  localparam int CW = 8;

  typedef struct packed {
    fsc_pkg::fsc_state_e st;
    logic [CW-1:0]       cnt;
    logic [7:0]          code;
    logic [7:0]          sr;
    logic [1:0]          mode;
    logic                rp_assert;
    logic [3:0]          irq_st;
    logic [3:0]          irq_msk;
    logic                ack;
    logic [31:0]         rdata;
    logic                ce_n;
    logic                we_n;
    logic                oe_n;
    logic                doe;
    logic [7:0]          dout;
    logic                pin_prev;
    logic [CW-1:0]       low_cnt;
    logic                hold;
  } fsc_host_s;

  fsc_host_s r_reg;
  fsc_host_s r_next;
  logic [8:0] pin_sync;
  logic [7:0] data_s;
  logic       pin_s;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  fsc_sync #(.WIDTH(9)) u_sync (
    .ref_clk  (ref_clk),
    .reset_n  (reset_n),
    .async_in ({~status_pin, flash_data_in}),
    .sync_out (pin_sync)
  );
  // Pin enters inverted so a cleared synchroniser reads as an idle high pin
  assign data_s = pin_sync[7:0];
  assign pin_s  = ~pin_sync[8];

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [3:0] set_irq;
    logic       go;
    logic       active;
    logic       wr_st;
    logic       step_end;
    set_irq  = '0;
    go       = 1'b0;
    active   = 1'b0;
    wr_st    = 1'b0;
    step_end = 1'b0;
    r_next   = r_reg;

    // Avalon slave: one wait cycle, answer on the second edge
    r_next.ack = (avs_read | avs_write) & ~r_reg.ack;
    if (avs_read && !r_reg.ack) begin
      r_next.rdata = '0;
      case (avs_address)
        fsc_pkg::OFS_CTRL[3:2]: begin
          r_next.rdata[7:0] = r_reg.code;
          r_next.rdata[fsc_pkg::CTRL_RP_BIT] = r_reg.rp_assert;
        end
        fsc_pkg::OFS_STAT[3:2]: begin
          r_next.rdata[7:0] = r_reg.sr;
          r_next.rdata[fsc_pkg::STAT_BUSY_BIT] = r_reg.st != fsc_pkg::S_IDLE;
          r_next.rdata[fsc_pkg::STAT_RB_BIT] = pin_s;
          r_next.rdata[fsc_pkg::STAT_MODE_LSB +: 2] = r_reg.mode;
        end
        fsc_pkg::OFS_IRQ[3:2]:  r_next.rdata[3:0] = r_reg.irq_st;
        fsc_pkg::OFS_MASK[3:2]: r_next.rdata[3:0] = r_reg.irq_msk;
        default:                r_next.rdata = '0;
      endcase
    end
    if (avs_write && r_reg.ack && avs_byteenable[0]) begin
      case (avs_address)
        fsc_pkg::OFS_CTRL[3:2]: begin
          r_next.code      = avs_writedata[7:0];
          r_next.rp_assert = avs_writedata[fsc_pkg::CTRL_RP_BIT];
          go               = avs_writedata[fsc_pkg::CTRL_GO_BIT];
        end
        fsc_pkg::OFS_MASK[3:2]: r_next.irq_msk = avs_writedata[3:0];
        default: ;
      endcase
    end

    // Sequencer: one flash bus cycle per non-idle state, repeated in S_VS_R until ready
    step_end = r_reg.cnt == CW'(fsc_pkg::ACCESS_CYC + fsc_pkg::GAP_CYC - 1);
    if (r_reg.st != fsc_pkg::S_IDLE) begin
      r_next.cnt = step_end ? '0 : r_reg.cnt + 1'b1;
    end
    if (r_reg.st != fsc_pkg::S_IDLE &&
        r_reg.cnt == CW'(fsc_pkg::ACCESS_CYC - 1) &&
        (r_reg.st == fsc_pkg::S_RS_R || r_reg.st == fsc_pkg::S_VS_R)) begin
      r_next.sr = data_s;
    end
    case (r_reg.st)
      fsc_pkg::S_IDLE: begin
        if (go && !r_reg.rp_assert) begin
          r_next.st  = fsc_pkg::S_RS_W;
          r_next.cnt = '0;
        end
      end
      fsc_pkg::S_RS_W:  if (step_end) r_next.st = fsc_pkg::S_RS_R;
      fsc_pkg::S_RS_R: begin
        if (step_end) begin
          if (r_reg.sr[fsc_pkg::SR_READY]) begin
            r_next.st = fsc_pkg::S_CFG_W;
          end else begin
            set_irq[fsc_pkg::IRQ_REFUSED] = 1'b1;
            r_next.st = fsc_pkg::S_IDLE;
          end
        end
      end
      fsc_pkg::S_CFG_W:  if (step_end) r_next.st = fsc_pkg::S_CODE_W;
      fsc_pkg::S_CODE_W: if (step_end) r_next.st = fsc_pkg::S_VS_W;
      fsc_pkg::S_VS_W:   if (step_end) r_next.st = fsc_pkg::S_VS_R;
      fsc_pkg::S_VS_R: begin
        // Poll until ready, then judge the outcome by the error bits
        if (step_end && r_reg.sr[fsc_pkg::SR_READY]) begin
          if (r_reg.sr[fsc_pkg::SR_PROG_ERR] &&
              r_reg.sr[fsc_pkg::SR_ERASE_ERR]) begin
            set_irq[fsc_pkg::IRQ_ERR] = 1'b1;
            r_next.st = fsc_pkg::S_CLR_W;
          end else begin
            r_next.mode = r_reg.code[1:0];
            set_irq[fsc_pkg::IRQ_DONE] = 1'b1;
            r_next.st = fsc_pkg::S_IDLE;
          end
        end
      end
      fsc_pkg::S_CLR_W: if (step_end) r_next.st = fsc_pkg::S_IDLE;
      default:          r_next.st = fsc_pkg::S_IDLE;
    endcase

    // Reset-powerdown aborts the sequence and restores level mode
    if (r_reg.rp_assert) begin
      r_next.st   = fsc_pkg::S_IDLE;
      r_next.cnt  = '0;
      r_next.mode = fsc_pkg::MODE_LEVEL;
    end

    // Pin drive, decoded from the next state so outputs are registered
    active = r_next.st != fsc_pkg::S_IDLE &&
             r_next.cnt < CW'(fsc_pkg::ACCESS_CYC);
    wr_st  = r_next.st != fsc_pkg::S_RS_R && r_next.st != fsc_pkg::S_VS_R;
    r_next.ce_n = ~active;
    r_next.we_n = ~(active & wr_st);
    r_next.oe_n = ~(active & ~wr_st);
    r_next.doe  = active & wr_st;
    case (r_next.st)
      fsc_pkg::S_CFG_W:  r_next.dout = CONFIG_OPCODE;
      fsc_pkg::S_CODE_W: r_next.dout = r_reg.code;
      fsc_pkg::S_CLR_W:  r_next.dout = CLRSTAT_OPCODE;
      default:           r_next.dout = RDSTAT_OPCODE;
    endcase

    // Status pin: level mode feeds hold, pulse modes raise events
    r_next.pin_prev = pin_s;
    if (pin_s) begin
      r_next.low_cnt = '0;
    end else if (r_reg.low_cnt != '1) begin
      r_next.low_cnt = r_reg.low_cnt + 1'b1;
    end
    if (r_reg.mode != fsc_pkg::MODE_LEVEL && pin_s && !r_reg.pin_prev &&
        r_reg.low_cnt >= CW'(fsc_pkg::PULSE_MIN_CYC)) begin
      set_irq[fsc_pkg::IRQ_PULSE] = 1'b1;
    end
    r_next.hold = r_reg.mode == fsc_pkg::MODE_LEVEL && !pin_s;

    // Sticky events: a set in the clearing cycle wins
    r_next.irq_st = r_reg.irq_st;
    if (avs_write && r_reg.ack && avs_byteenable[0] &&
        avs_address == fsc_pkg::OFS_IRQ[3:2]) begin
      r_next.irq_st = r_reg.irq_st & ~avs_writedata[3:0];
    end
    r_next.irq_st = r_next.irq_st | set_irq;
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      r_reg          <= '0;
      r_reg.st       <= fsc_pkg::S_IDLE;
      r_reg.code     <= fsc_pkg::CODE_RESET;
      r_reg.mode     <= fsc_pkg::MODE_LEVEL;
      r_reg.irq_st   <= fsc_pkg::IRQ_RESET;
      r_reg.irq_msk  <= fsc_pkg::IRQ_RESET;
      r_reg.ce_n     <= 1'b1;
      r_reg.we_n     <= 1'b1;
      r_reg.oe_n     <= 1'b1;
      r_reg.pin_prev <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign avs_waitrequest   = (avs_read | avs_write) & ~r_reg.ack;
  assign avs_readdata      = r_reg.rdata;
  assign irq               = |(r_reg.irq_st & r_reg.irq_msk);
  assign flash_ce_n        = r_reg.ce_n;
  assign flash_we_n        = r_reg.we_n;
  assign flash_oe_n        = r_reg.oe_n;
  assign flash_data_out    = r_reg.dout;
  assign flash_data_oe     = r_reg.doe;
  assign reset_powerdown_n = ~r_reg.rp_assert;
  assign hold_request      = r_reg.hold;

endmodule

//--- core/fsc_pkg.sv
// Shared constants and types for the flash status pin configuration host
package fsc_pkg;

  // ----------------------------------------------------------------
  // Clock and pin timing
  // ----------------------------------------------------------------
  localparam int CLK_NS     = 8;
  localparam int ACCESS_NS  = 120;
  localparam int ACCESS_CYC = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam int GAP_CYC    = 2;
  localparam int PULSE_NS   = 250;
  // Glitch floor: a quarter of the nominal pulse, so slow parts still count
  localparam int PULSE_MIN_CYC = (PULSE_NS / 4) / CLK_NS;

  // ----------------------------------------------------------------
  // Register byte offsets (Avalon word index is offset[3:2])
  // ----------------------------------------------------------------
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_STAT = 4'h4;
  localparam logic [3:0] OFS_IRQ  = 4'h8;
  localparam logic [3:0] OFS_MASK = 4'hC;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_GO_BIT   = 8;
  localparam int CTRL_RP_BIT   = 9;
  localparam int STAT_BUSY_BIT = 8;
  localparam int STAT_RB_BIT   = 9;
  localparam int STAT_MODE_LSB = 10;
  localparam int SR_PROG_ERR   = 4;
  localparam int SR_ERASE_ERR  = 5;
  localparam int SR_READY      = 7;
  localparam int IRQ_PULSE     = 0;
  localparam int IRQ_DONE      = 1;
  localparam int IRQ_ERR       = 2;
  localparam int IRQ_REFUSED   = 3;
  localparam int CODE_ERASE_BIT = 0;
  localparam int CODE_PROG_BIT  = 1;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CODE_RESET = 8'h00;
  localparam logic [1:0] MODE_LEVEL = 2'h0;
  localparam logic [3:0] IRQ_RESET  = 4'h0;

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    S_IDLE,
    S_RS_W,
    S_RS_R,
    S_CFG_W,
    S_CODE_W,
    S_VS_W,
    S_VS_R,
    S_CLR_W
  } fsc_state_e;

endpackage

//--- core/fsc_sync.sv
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ns
module fsc_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             reset_n,
  // Data
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } fsc_sync_s;

  fsc_sync_s sync_reg;
  fsc_sync_s sync_next;

  always_comb begin
    sync_next        = sync_reg;
    sync_next.stage1 = async_in;
    sync_next.stage2 = sync_reg.stage1;
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sync_reg <= '0;
    end else begin
      sync_reg <= sync_next;
    end
  end

  assign sync_out = sync_reg.stage2;

endmodule

//--- dv/fsc_flash_model.sv
// Behavioural flash part as seen from its pins
`timescale 1ns/1ns
module fsc_flash_model #(
  parameter logic [7:0] CFG_OP    = 8'hB8,
  parameter logic [7:0] CLR_OP    = 8'h50,
  parameter logic [7:0] OBS_OP    = 8'h60,
  parameter int         PULSE_CYC = 31
) (
  // Pins
  input  wire logic       ref_clk,
  input  wire logic       ce_n,
  input  wire logic       we_n,
  input  wire logic       oe_n,
  input  wire logic [7:0] dq,
  output logic      [7:0] q,
  input  wire logic       rp_n,
  output logic            sts,
  // Bench controls: machine busy, completions, supply below lockout
  input  wire logic       busy,
  input  wire logic [1:0] done,
  input  wire logic       lockout
);
  logic [7:0] sr   = 8'h80;
  logic [7:0] wb   = 8'h00;
  logic [7:0] last = 8'h00;
  logic [1:0] mode = 2'h0;
  logic       cfg  = 1'b0;
  logic       we_q = 1'b1;
  int         cnt  = 0;
  // Released bus shows the inverse of its last value, never a stale copy
  assign q   = (!ce_n && !oe_n) ? sr : ~last;
  assign sts = (mode == 2'h0) ? !busy : (cnt == 0);
  always @(posedge ref_clk) begin
    we_q  <= we_n;
    sr[7] <= !busy;
    if (!ce_n && !oe_n) last <= sr;
    if (!we_n && !ce_n) wb <= dq;
    // Below lockout no erase or program can complete, so nothing pulses
    if (|(done & mode) && !lockout) cnt <= PULSE_CYC;
    else if (cnt != 0) cnt <= cnt - 1;
    if (!rp_n) begin
      mode <= 2'h0;
      cfg  <= 1'b0;
    end else if (we_n && !we_q) begin
      cfg <= (wb == CFG_OP) && !cfg;
      if (cfg && wb[7:2] != 6'h00) sr[5:4] <= 2'h3;
      else if (cfg) mode <= wb[1:0];
      else if (wb == CLR_OP) sr[5:4] <= 2'h0;
      else if (wb == OBS_OP) sr[5:4] <= 2'h3;
    end
  end
endmodule

//--- dv/fsc_host_monitor.sv
// Protocol checker for the flash status pin host
`timescale 1ns/1ns
module fsc_host_monitor #(
  parameter logic [7:0] CONFIG_OPCODE = 8'hB8
) (
  // Clock, reset and Avalon
  input wire logic       ref_clk,
  input wire logic       reset_n,
  input wire logic       avs_read,
  input wire logic       avs_write,
  input wire logic       avs_waitrequest,
  // Flash side
  input wire logic       flash_ce_n,
  input wire logic       flash_we_n,
  input wire logic       flash_oe_n,
  input wire logic [7:0] flash_data_out,
  input wire logic       flash_data_oe,
  input wire logic       reset_powerdown_n,
  input wire logic       status_pin,
  input wire logic       hold_request
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  sequence s_wr;
    (!flash_we_n && flash_data_oe)[*8] ##1
    (!flash_we_n && flash_data_oe)[*7] ##1 flash_we_n;
  endsequence
  sequence s_rd;
    (!flash_oe_n && !flash_ce_n)[*8] ##1
    (!flash_oe_n && !flash_ce_n)[*7] ##1 flash_oe_n;
  endsequence
  property p_answer;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  property p_we_ce;
    !flash_we_n |-> !flash_ce_n;
  endproperty
  property p_no_clash;
    !flash_oe_n |-> flash_we_n && !flash_data_oe && !flash_ce_n;
  endproperty
  property p_wr;
    $fell(flash_we_n) |-> s_wr;
  endproperty
  property p_rd;
    $fell(flash_oe_n) |-> s_rd;
  endproperty
  // Code byte must be the very next write after the opcode
  property p_cfg_code;
    $fell(flash_we_n) && flash_data_out == CONFIG_OPCODE
      |-> s_wr ##2 $fell(flash_we_n);
  endproperty
  property p_hold;
    hold_request |-> !$past(status_pin, 3);
  endproperty
  property p_rp_idle;
    !reset_powerdown_n |=> flash_ce_n && !flash_data_oe;
  endproperty
  a_answer: assert property (p_answer) else $error("bus hang");
  a_we_ce: assert property (p_we_ce) else $error("we w/o ce");
  a_no_clash: assert property (p_no_clash) else $error("clash");
  a_wr: assert property (p_wr) else $error("bad write");
  a_rd: assert property (p_rd) else $error("bad read");
  a_cfg_code: assert property (p_cfg_code) else $error("no code");
  a_hold: assert property (p_hold) else $error("bad hold");
  a_rp_idle: assert property (p_rp_idle) else $error("rp busy");
endmodule
bind fsc_host fsc_host_monitor #(.CONFIG_OPCODE(CONFIG_OPCODE)) u_mon (
  .ref_clk(ref_clk), .reset_n(reset_n), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
  .flash_ce_n(flash_ce_n), .flash_we_n(flash_we_n),
  .flash_oe_n(flash_oe_n), .flash_data_out(flash_data_out),
  .flash_data_oe(flash_data_oe), .reset_powerdown_n(reset_powerdown_n),
  .status_pin(status_pin), .hold_request(hold_request));

//--- dv/fsc_host_tb.sv
// Self-checking bench for the flash status pin host
`timescale 1ns/1ns
module fsc_host_tb;
  logic        ref_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [1:0]  avs_address = 2'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'hF;
  logic [31:0] avs_readdata, q;
  logic        avs_waitrequest, irq, flash_ce_n, flash_we_n, flash_oe_n;
  logic [7:0]  flash_data_out, fl_q, dq;
  logic        flash_data_oe, reset_powerdown_n, status_pin, hold_request;
  logic        busy = 1'b0;
  logic        lockout = 1'b0;
  logic [1:0]  done = 2'h0;
  int          failures = 0;
  int          samples_checked = 0;
  assign dq = flash_data_oe ? flash_data_out : fl_q;
  fsc_host uut (.ref_clk(ref_clk), .reset_n(reset_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .irq(irq), .flash_ce_n(flash_ce_n), .flash_we_n(flash_we_n),
    .flash_oe_n(flash_oe_n), .flash_data_out(flash_data_out),
    .flash_data_oe(flash_data_oe), .flash_data_in(dq),
    .reset_powerdown_n(reset_powerdown_n), .status_pin(status_pin),
    .hold_request(hold_request));
  fsc_flash_model flash (.ref_clk(ref_clk), .ce_n(flash_ce_n),
    .we_n(flash_we_n), .oe_n(flash_oe_n), .dq(dq), .q(fl_q),
    .rp_n(reset_powerdown_n), .sts(status_pin), .busy(busy), .done(done),
    .lockout(lockout));
  initial begin
    forever #4 ref_clk = ~ref_clk;
  end
  task automatic finish_test;
    if (failures == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  // Extra edge at the end keeps back-to-back strobes from double assigning
  task automatic bus(input logic w, input logic [1:0] a,
                     input logic [31:0] d, input logic [3:0] be);
    int n;
    n = 0;
    avs_address    <= a;
    avs_writedata  <= d;
    avs_byteenable <= be;
    avs_write      <= w;
    avs_read       <= !w;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    if (n >= 20) failures++;
    @(posedge ref_clk);
  endtask
  task automatic cfg(input logic [7:0] c, input int b, input logic [11:0] e);
    int n;
    n = 0;
    // Earlier pulse events would otherwise show up in the done check
    bus(1'b1, 2'h2, 32'hF, 4'hF);
    bus(1'b1, 2'h0, {24'h000001, c}, 4'hF);
    q = 32'h0;
    while (q[b] !== 1'b1 && n < 100) begin
      bus(1'b0, 2'h2, 32'h0, 4'hF);
      n++;
    end
    chk(q[3:0], 4'h1 << b);
    bus(1'b1, 2'h2, 32'hF, 4'hF);
    repeat (20) @(posedge ref_clk);
    bus(1'b0, 2'h1, 32'h0, 4'hF);
    chk(q[11:0], e);
  endtask
  task automatic fire(input logic [1:0] e);
    bus(1'b1, 2'h2, 32'hF, 4'hF);
    done <= e;
    @(posedge ref_clk);
    done <= 2'h0;
    repeat (50) @(posedge ref_clk);
    bus(1'b0, 2'h2, 32'h0, 4'hF);
  endtask
  task automatic t_reset;
    bus(1'b0, 2'h1, 32'h0, 4'hF);
    chk(q, 32'h00000200);
    bus(1'b0, 2'h2, 32'h0, 4'hF);
    chk(q, 32'h0);
    chk({irq, hold_request, reset_powerdown_n}, 3'b001);
  endtask
  task automatic t_level;
    busy <= 1'b1;
    repeat (6) @(posedge ref_clk);
    chk(hold_request, 1'b1);
    bus(1'b0, 2'h1, 32'h0, 4'hF);
    chk(q[9:8], 2'b00);
    busy <= 1'b0;
    repeat (6) @(posedge ref_clk);
    chk(hold_request, 1'b0);
  endtask
  task automatic t_modes;
    for (int c = 1; c < 4; c++) begin
      cfg(c[7:0], 1, {c[1:0], 10'h280});
      bus(1'b1, 2'h3, 32'h1, 4'hF);
      fire(2'b01);
      chk(q[0], c[0]);
      chk(irq, c[0]);
      bus(1'b1, 2'h3, 32'h0, 4'hF);
      fire(2'b10);
      chk(q[0], c[1]);
      chk(irq, 1'b0);
    end
  endtask
  task automatic t_rp;
    cfg(8'h01, 1, 12'h680);
    lockout <= 1'b1;
    fire(2'b01);
    chk(q[0], 1'b0);
    lockout <= 1'b0;
    bus(1'b1, 2'h0, 32'h200, 4'hF);
    repeat (2) @(posedge ref_clk);
    chk(reset_powerdown_n, 1'b0);
    bus(1'b1, 2'h0, 32'h0, 4'hF);
    bus(1'b0, 2'h1, 32'h0, 4'hF);
    chk(q[11:10], 2'b00);
    fire(2'b01);
    chk(q[3:0], 4'h0);
    bus(1'b1, 2'h3, 32'hF, 4'hE);
    bus(1'b0, 2'h3, 32'h0, 4'hF);
    chk(q[3:0], 4'h0);
  endtask
  initial begin
    repeat (6) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    t_reset();
    t_level();
    t_modes();
    cfg(8'h04, 2, 12'hEB0);
    cfg(8'h00, 1, 12'h280);
    busy <= 1'b1;
    repeat (4) @(posedge ref_clk);
    cfg(8'h01, 3, 12'h000);
    busy <= 1'b0;
    t_rp();
    finish_test();
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    finish_test();
  end
endmodule
